// ===== tct_params.svh
/*
 * Constants of the TLB and cache test-register block: register numbers,
 * field positions, reset values and array sizes.
 * Assumes it is included by bare name from the package and the design.
 */
`ifndef TCT_PARAMS_SVH
`define TCT_PARAMS_SVH

// Test register numbers as carried by the move-to/from instruction.
`define TCT_REG_BUF_WORD 3'h3
`define TCT_REG_TAG_STATE 3'h4
`define TCT_REG_SELECT 3'h5
`define TCT_REG_TLB_CTRL 3'h6
`define TCT_REG_TLB_DATA 3'h7

// TLB test data register fields.
`define TCT_TD_PA_MSB 31
`define TCT_TD_PA_LSB 12
`define TCT_TD_LRU_MSB 9
`define TCT_TD_LRU_LSB 7
`define TCT_TD_HIT 4
`define TCT_TD_SET_MSB 3
`define TCT_TD_SET_LSB 2
`define TCT_TD_WMASK 32'hffff_f01c

// TLB test control register fields.
`define TCT_TC_LA_MSB 31
`define TCT_TC_LA_LSB 12
`define TCT_TC_VALID 11
`define TCT_TC_DIRTY_MSB 10
`define TCT_TC_DIRTY_LSB 9
`define TCT_TC_USER_MSB 8
`define TCT_TC_USER_LSB 7
`define TCT_TC_RW_MSB 6
`define TCT_TC_RW_LSB 5
`define TCT_TC_CMD 0
`define TCT_TC_WMASK 32'hffff_ffe1

// Cache test select register fields.
`define TCT_CS_LINE_MSB 11
`define TCT_CS_LINE_LSB 4
`define TCT_CS_SET_MSB 3
`define TCT_CS_SET_LSB 2
`define TCT_CS_WMASK 32'h0000_0fff

// Cache tag/state register fields.
`define TCT_TS_TAG_MSB 31
`define TCT_TS_TAG_LSB 12
`define TCT_TS_VALID 10
`define TCT_TS_LRU_MSB 9
`define TCT_TS_LRU_LSB 7
`define TCT_TS_DIRTY_MSB 6
`define TCT_TS_DIRTY_LSB 3
`define TCT_TS_WMASK 32'hffff_f7f8

// Sizes and reset values.
`define TCT_TLB_LINES 8
`define TCT_CACHE_LINES 256
`define TCT_WAYS 4
`define TCT_LINE_DWORDS 4
`define TCT_REG_RESET 32'h0000_0000
`define TCT_LRU_RESET 3'h0

`endif

// ===== tct_pkg.sv
/*
 * Types of the TLB and cache test-register block.
 * Assumes tct_params.svh is on the include path.
 */
package tct_pkg;
  `include "tct_params.svh"

  // Cache test operation codes held in bits 1:0 of the select register.
  typedef enum logic [1:0] {
    TCT_OP_BUFFER = 2'h0,
    TCT_OP_CWRITE = 2'h1,
    TCT_OP_CREAD = 2'h2,
    TCT_OP_CFLUSH = 2'h3
  } tct_cop_e;

  // One move to or from a test register.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] num;
    logic [31:0] wdata;
  } tct_req_s;

  // Attribute bits of a TLB entry (true polarity).
  typedef struct packed {
    logic dirty;
    logic user;
    logic rw;
  } tct_attr_s;
endpackage

// ===== tct_test_regs.sv
/*
 * Test registers for the 32-entry four-way TLB and the 16 KB four-way
 * write-back cache, reached by moves to and from test register numbers.
 * Assumes one request per cycle from the instruction unit, synchronous
 * to core_clk_i, with the current privilege level alongside.
 */
`timescale 1ns/1ps
`include "tct_params.svh"
// What this block does
// R1 - Lookup returns page; write stores page
// R2 - Lookup returns prior LRU; write ignores it
// R3 - Hit flag set on hit, cleared on miss
// R4 - Write: flag picks forced set or replacement
// R5 - Hit reports matching set in bits 3:2
// R6 - Forced write set from set-selection field
// R7 - Lookup searches control register linear address
// R8 - Hit updates control attributes and data fields
// R9 - Write allocates entry to control linear address
// R10 - Write valid bit sets or invalidates entry
// R11 - Three attribute pairs; 00 or 11 means bit not compared
// R12 - Command bit: 1 lookup, 0 write
// R13 - Access only at privilege level zero
// R14 - Cache: 16 KB, four ways, 256 lines
// R15 - Entry: tag, 16 bytes, valid, four dirty
// R16 - One dirty bit per DWORD
// R17 - Three LRU bits per cache line
// R18 - Line chosen by address bits 11:4
// R19 - Fill and flush buffers carry test data
// R20 - Select control field encodes cache operation
// R21 - Software fills four DWORDs before cache write
// R22 - Reserved bits written zero, read zero
module tct_test_regs
  import tct_pkg::*;
#(
  parameter int TLB_LINES = `TCT_TLB_LINES,
  parameter int CACHE_LINES = `TCT_CACHE_LINES
)
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire tct_req_s req_i,
  input wire logic [1:0] cpl_i,
  output logic [31:0] rd_data_o,
  output logic rd_valid_o,
  output logic priv_fault_o
);
  localparam int TIW = $clog2(`TCT_TLB_LINES);
  localparam int WAYS = `TCT_WAYS;

  logic [31:0] tlb_data_ff;
  logic [31:0] tlb_ctrl_ff;
  logic [31:0] sel_ff;
  logic [31:0] tag_state_ff;
  logic [31:0] rd_data_ff;
  logic rd_valid_ff;
  logic priv_fault_ff;

  logic [31:0] fill_ff [`TCT_LINE_DWORDS];
  logic [31:0] flush_ff [`TCT_LINE_DWORDS];

  logic [127:0] cdata_ff [CACHE_LINES][WAYS]; // R14
  logic [19:0] ctag_ff [CACHE_LINES][WAYS];
  logic cvalid_ff [CACHE_LINES][WAYS];
  logic [3:0] cdirty_ff [CACHE_LINES][WAYS];
  logic [2:0] clru_ff [CACHE_LINES];
  logic [2:0] tlru_ff [TLB_LINES];

  logic allowed;
  logic wr_go;
  logic rd_go;
  logic tlb_go;
  logic tlb_lookup;
  logic tlb_write;
  logic cop_go;
  tct_cop_e cop;
  logic [TIW-1:0] tidx;
  logic [19:0] tla;
  logic [WAYS-1:0] way_hit;
  logic [19:0] way_data [WAYS];
  tct_attr_s way_attr [WAYS];
  logic [WAYS-1:0] way_wr;
  logic any_hit;
  logic [1:0] hit_set;
  logic [1:0] victim;
  logic [1:0] wr_set;
  tct_attr_s wr_attr;
  logic [7:0] cline;
  logic [1:0] cset;
  logic [1:0] dsel;
  logic [31:0] rd_mux;

  initial
  begin
    if (TLB_LINES != `TCT_TLB_LINES || CACHE_LINES != `TCT_CACHE_LINES)
    begin
      $error("tct_test_regs: array sizes are fixed by the field layout");
    end
  end

  // A refused move has no effect at all and is flagged for a fault.
  assign allowed = (cpl_i == 2'h0); // R13
  assign wr_go = req_i.wr && allowed;
  assign rd_go = req_i.rd && allowed;

  // Writing the control register starts the TLB operation.
  assign tlb_go = wr_go && (req_i.num == `TCT_REG_TLB_CTRL);
  assign tlb_lookup = tlb_go && req_i.wdata[`TCT_TC_CMD]; // R12
  assign tlb_write = tlb_go && !req_i.wdata[`TCT_TC_CMD];
  assign tla = req_i.wdata[`TCT_TC_LA_MSB:`TCT_TC_LA_LSB]; // R7
  assign tidx = tla[TIW-1:0];

  // Writing the select register starts the cache operation it encodes.
  assign cop_go = wr_go && (req_i.num == `TCT_REG_SELECT);
  assign cop = tct_cop_e'(req_i.wdata[1:0]); // R20
  assign cline = req_i.wdata[`TCT_CS_LINE_MSB:`TCT_CS_LINE_LSB]; // R18
  assign cset = req_i.wdata[`TCT_CS_SET_MSB:`TCT_CS_SET_LSB];
  assign dsel = sel_ff[`TCT_CS_SET_MSB:`TCT_CS_SET_LSB];

  assign wr_attr.dirty = req_i.wdata[`TCT_TC_DIRTY_MSB]; // R11
  assign wr_attr.user = req_i.wdata[`TCT_TC_USER_MSB];
  assign wr_attr.rw = req_i.wdata[`TCT_TC_RW_MSB];

  // Pseudo-LRU victim: bit 0 says which half was used last.
  always_comb
  begin
    if (tlru_ff[tidx][0])
      victim = tlru_ff[tidx][2] ? 2'h3 : 2'h2;
    else
      victim = tlru_ff[tidx][1] ? 2'h1 : 2'h0;
  end

  always_comb
  begin
    if (tlb_data_ff[`TCT_TD_HIT])
      wr_set = tlb_data_ff[`TCT_TD_SET_MSB:`TCT_TD_SET_LSB]; // R6
    else
      wr_set = victim; // R4
  end

  genvar w;
  generate
    for (w = 0; w < WAYS; w++)
    begin : g_way
      assign way_wr[w] = tlb_write && (wr_set == 2'(w)); // R9
      tct_tlb_way #(
        .LINES(TLB_LINES),
        .IW(TIW)
      ) u_way (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .idx_i(tidx),
        .cmp_tag_i(tla),
        .cmp_pairs_i(req_i.wdata[`TCT_TC_DIRTY_MSB:`TCT_TC_RW_LSB]),
        .wr_en_i(way_wr[w]),
        .wr_valid_i(req_i.wdata[`TCT_TC_VALID]), // R10
        .wr_attr_i(wr_attr),
        .wr_data_i(tlb_data_ff[`TCT_TD_PA_MSB:`TCT_TD_PA_LSB]), // R1
        .hit_o(way_hit[w]),
        .data_o(way_data[w]),
        .attr_o(way_attr[w])
      );
    end
  endgenerate

  assign any_hit = |way_hit;

  always_comb
  begin
    hit_set = 2'h0;
    for (int i = WAYS - 1; i >= 0; i--)
    begin
      if (way_hit[i])
        hit_set = i[1:0];
    end
  end

  // TLB data register: software writes, lookups load results.
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tlb_data_ff <= `TCT_REG_RESET;
    end
    else if (wr_go && req_i.num == `TCT_REG_TLB_DATA)
    begin
      tlb_data_ff <= req_i.wdata & `TCT_TD_WMASK; // R22
    end
    else if (tlb_lookup)
    begin
      tlb_data_ff[`TCT_TD_LRU_MSB:`TCT_TD_LRU_LSB] <= tlru_ff[tidx]; // R2
      tlb_data_ff[`TCT_TD_HIT] <= any_hit; // R3
      if (any_hit)
      begin
        tlb_data_ff[`TCT_TD_PA_MSB:`TCT_TD_PA_LSB] <= way_data[hit_set]; // R8
        tlb_data_ff[`TCT_TD_SET_MSB:`TCT_TD_SET_LSB] <= hit_set; // R5
      end
    end
  end

  // TLB control register; a hit rewrites the attribute pairs.
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tlb_ctrl_ff <= `TCT_REG_RESET;
    end
    else if (tlb_go)
    begin
      tlb_ctrl_ff <= req_i.wdata & `TCT_TC_WMASK; // R22
      if (tlb_lookup && any_hit)
      begin
        tlb_ctrl_ff[`TCT_TC_DIRTY_MSB:`TCT_TC_RW_LSB] <= {
          way_attr[hit_set].dirty, !way_attr[hit_set].dirty,
          way_attr[hit_set].user, !way_attr[hit_set].user,
          way_attr[hit_set].rw, !way_attr[hit_set].rw}; // R8
      end
    end
  end

  // TLB LRU: a hit or a write marks the way as most recently used.
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < TLB_LINES; i++)
        tlru_ff[i] <= `TCT_LRU_RESET;
    end
    else if ((tlb_lookup && any_hit) || tlb_write)
    begin
      if (tlb_write)
        tlru_ff[tidx] <= nxt_lru(tlru_ff[tidx], wr_set);
      else
        tlru_ff[tidx] <= nxt_lru(tlru_ff[tidx], hit_set);
    end
  end

  function automatic logic [2:0] nxt_lru(input logic [2:0] cur,
                                         input logic [1:0] set);
    logic [2:0] n;
    n = cur;
    n[0] = !set[1];
    if (set[1])
      n[2] = !set[0];
    else
      n[1] = !set[0];
    return n;
  endfunction

  // Cache select and tag/state registers.
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sel_ff <= `TCT_REG_RESET;
    end
    else if (cop_go)
    begin
      sel_ff <= req_i.wdata & `TCT_CS_WMASK;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tag_state_ff <= `TCT_REG_RESET;
    end
    else if (wr_go && req_i.num == `TCT_REG_TAG_STATE)
    begin
      tag_state_ff <= req_i.wdata & `TCT_TS_WMASK;
    end
    else if (cop_go && cop == TCT_OP_CREAD)
    begin
      tag_state_ff <= {ctag_ff[cline][cset], 1'b0,
                       cvalid_ff[cline][cset], clru_ff[cline],
                       cdirty_ff[cline][cset], 3'h0}; // R17
    end
  end

  // Fill buffer takes one DWORD per buffer-word write; flush buffer takes
  // a whole line on a cache read.
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < `TCT_LINE_DWORDS; i++)
      begin
        fill_ff[i] <= `TCT_REG_RESET;
        flush_ff[i] <= `TCT_REG_RESET;
      end
    end
    else
    begin
      if (wr_go && req_i.num == `TCT_REG_BUF_WORD)
        fill_ff[dsel] <= req_i.wdata; // R19
      if (cop_go && cop == TCT_OP_CREAD)
      begin
        for (int i = 0; i < `TCT_LINE_DWORDS; i++)
          flush_ff[i] <= cdata_ff[cline][cset][32*i +: 32]; // R19
      end
    end
  end

  // Cache line data; a cache write moves the whole fill buffer at once.
  always_ff @(posedge core_clk_i)
  begin
    if (cop_go && cop == TCT_OP_CWRITE)
    begin
      cdata_ff[cline][cset] <= {fill_ff[3], fill_ff[2],
                                fill_ff[1], fill_ff[0]}; // R21
    end
  end

  // Cache tags and state; a flush invalidates and cleans every entry.
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int l = 0; l < CACHE_LINES; l++)
      begin
        clru_ff[l] <= `TCT_LRU_RESET;
        for (int s = 0; s < WAYS; s++)
        begin
          ctag_ff[l][s] <= 20'h0;
          cvalid_ff[l][s] <= 1'b0;
          cdirty_ff[l][s] <= 4'h0;
        end
      end
    end
    else if (cop_go && cop == TCT_OP_CWRITE)
    begin
      ctag_ff[cline][cset] <= tag_state_ff[`TCT_TS_TAG_MSB:`TCT_TS_TAG_LSB];
      cvalid_ff[cline][cset] <= tag_state_ff[`TCT_TS_VALID]; // R15
      cdirty_ff[cline][cset] <=
        tag_state_ff[`TCT_TS_DIRTY_MSB:`TCT_TS_DIRTY_LSB]; // R16
      clru_ff[cline] <= nxt_lru(clru_ff[cline], cset); // R17
    end
    else if (cop_go && cop == TCT_OP_CFLUSH)
    begin
      for (int l = 0; l < CACHE_LINES; l++)
      begin
        for (int s = 0; s < WAYS; s++)
        begin
          cvalid_ff[l][s] <= 1'b0;
          cdirty_ff[l][s] <= 4'h0;
        end
      end
    end
  end

  // Read path: reserved bits are already zero in every stored register.
  always_comb
  begin
    case (req_i.num)
      `TCT_REG_TLB_DATA: rd_mux = tlb_data_ff;
      `TCT_REG_TLB_CTRL: rd_mux = tlb_ctrl_ff;
      `TCT_REG_SELECT: rd_mux = sel_ff;
      `TCT_REG_TAG_STATE: rd_mux = tag_state_ff;
      `TCT_REG_BUF_WORD: rd_mux = flush_ff[dsel]; // R19
      default: rd_mux = 32'h0; // R22
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_data_ff <= `TCT_REG_RESET;
      rd_valid_ff <= 1'b0;
      priv_fault_ff <= 1'b0;
    end
    else
    begin
      rd_valid_ff <= rd_go;
      priv_fault_ff <= (req_i.rd || req_i.wr) && !allowed; // R13
      if (rd_go)
        rd_data_ff <= rd_mux;
    end
  end

  assign rd_data_o = rd_data_ff;
  assign rd_valid_o = rd_valid_ff;
  assign priv_fault_o = priv_fault_ff;
endmodule

// ===== tct_test_regs_bench.sv
/*
 * Self-checking bench for the test-register block: reset values,
 * privilege refusal, TLB write and lookup, cache fill, read and flush.
 * Assumes the checker is bound to the design and inputs change at negedge.
 */
`timescale 1ns/1ps
module tct_test_regs_bench;
  import tct_pkg::*;
  logic core_clk_i;
  logic rst_n_i;
  tct_req_s req_i;
  logic [1:0] cpl_i;
  logic [31:0] rd_data_o;
  logic rd_valid_o;
  logic priv_fault_o;
  logic [31:0] d;
  int fails;
  int cmp_count;

  tct_test_regs dut_u (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .req_i(req_i),
    .cpl_i(cpl_i),
    .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o),
    .priv_fault_o(priv_fault_o)
  );

  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic tally_and_finish();
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  // Strobes stay up until the next call, so back-to-back requests work.
  task automatic put(input logic r, input logic w, input logic [2:0] n,
                     input logic [31:0] v);
    req_i = '{rd: r, wr: w, num: n, wdata: v};
    @(negedge core_clk_i);
  endtask

  task automatic wr(input logic [2:0] n, input logic [31:0] v);
    put(1'b0, 1'b1, n, v);
  endtask

  task automatic idle();
    req_i = '0;
    @(negedge core_clk_i);
  endtask

  task automatic rd(input logic [2:0] n, output logic [31:0] v);
    put(1'b1, 1'b0, n, 32'h0);
    chk("rd_valid", 32'h1, {31'h0, rd_valid_o});
    v = rd_data_o;
    req_i = '0;
    @(negedge core_clk_i);
  endtask

  task automatic s_reset();
    for (int n = 0; n < 8; n++)
    begin
      rd(3'(n), d);
      chk("reset_value", 32'h0, d);
    end
  endtask

  task automatic s_priv();
    cpl_i = 2'h3;
    wr(3'h5, 32'h0000_0123);
    chk("fault_wr", 32'h1, {31'h0, priv_fault_o});
    cpl_i = 2'h1;
    put(1'b1, 1'b0, 3'h7, 32'h0);
    chk("fault_rd", 32'h1, {31'h0, priv_fault_o});
    chk("refused_valid", 32'h0, {31'h0, rd_valid_o});
    idle();
    cpl_i = 2'h0;
    rd(3'h5, d);
    chk("select_kept", 32'h0, d);
    wr(3'h5, 32'h0000_0ab4);
    rd(3'h5, d);
    chk("select_echo", 32'h0000_0ab4, d);
  endtask

  task automatic s_tlb();
    wr(3'h7, 32'habcd_e018);
    wr(3'h6, 32'h1234_5cc0);
    wr(3'h6, 32'h1234_5001);
    rd(3'h7, d);
    chk("tlb_hit_data", 32'habcd_e218, d);
    rd(3'h6, d);
    chk("tlb_attr", 32'h1234_54c1, d & 32'hffff_f7ff);
    wr(3'h6, 32'h1234_5201);
    rd(3'h7, d);
    chk("tlb_attr_miss", 32'h0, d & 32'h10);
    wr(3'h7, 32'h7654_3000);
    wr(3'h6, 32'h0004_5cc0);
    wr(3'h6, 32'h0004_5001);
    rd(3'h7, d);
    chk("tlb_repl_hit", 32'h7654_3010, d & 32'hffff_f010);
    chk("tlb_repl_set", 32'h0, {30'h0, d[3:2]});
    wr(3'h7, 32'habcd_e018);
    wr(3'h6, 32'h1234_5000);
    wr(3'h6, 32'h1234_5001);
    rd(3'h7, d);
    chk("tlb_invalid", 32'h0, d & 32'h10);
  endtask

  task automatic s_cache();
    for (int i = 0; i < 4; i++)
    begin
      wr(3'h5, 32'h0000_0ff0 | 32'(i << 2));
      wr(3'h3, 32'h0f0f_0000 + 32'(i));
    end
    wr(3'h4, 32'h5a5a_5450);
    wr(3'h5, 32'h0000_0ff5);
    wr(3'h4, 32'h0);
    wr(3'h5, 32'h0000_0ff6);
    rd(3'h4, d);
    chk("cache_tag_state", 32'h5a5a_54d0, d);
    for (int i = 0; i < 4; i++)
    begin
      wr(3'h5, 32'h0000_0ff0 | 32'(i << 2));
      rd(3'h3, d);
      chk("flush_word", 32'h0f0f_0000 + 32'(i), d);
    end
    wr(3'h5, 32'h0000_0ff7);
    wr(3'h5, 32'h0000_0ff6);
    rd(3'h4, d);
    chk("cache_flushed", 32'h5a5a_5000, d & 32'hffff_fc7f);
  endtask

  initial
  begin
    #100000;
    fails++;
    tally_and_finish();
  end

  initial
  begin
    fails = 0;
    cmp_count = 0;
    rst_n_i = 1'b0;
    cpl_i = 2'h0;
    req_i = '0;
    d = 32'h0;
    repeat (2) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    s_reset();
    s_priv();
    s_tlb();
    s_cache();
    idle();
    tally_and_finish();
  end
endmodule

// ===== tct_test_regs_sva.sv
/*
 * Checker for the test-register block: answers, refusals, read-data hold,
 * reserved read bits and select register echo.
 * Assumes it is bound to tct_test_regs and sees only its ports.
 */
`timescale 1ns/1ps
module tct_test_regs_sva
  import tct_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire tct_req_s req_i,
  input wire logic [1:0] cpl_i,
  input wire logic [31:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic priv_fault_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  wire logic ok = cpl_i == 2'h0;
  wire logic rq = req_i.rd | req_i.wr;
  wire logic rd_ok = req_i.rd & ok;

  rd_answer_a: assert property (rd_ok |=> rd_valid_o && !priv_fault_o)
    else $error("accepted read not answered");
  priv_refuse_a: assert property (rq && !ok |=> priv_fault_o && !rd_valid_o)
    else $error("request at nonzero level not refused");
  no_spur_fault_a: assert property (!(rq && !ok) |=> !priv_fault_o)
    else $error("fault without refused request");
  no_spur_valid_a: assert property (!rd_ok |=> !rd_valid_o)
    else $error("read valid without accepted read");
  rdata_hold_a: assert property (!rd_valid_o |-> $stable(rd_data_o))
    else $error("read data moved without a read");
  tdata_reserved_zero_a: assert property (rd_ok && req_i.num == 3'h7
    |=> (rd_data_o & 32'h0000_0c63) == 32'h0)
    else $error("data register reserved bits not zero");
  tctl_reserved_zero_a: assert property (rd_ok && req_i.num == 3'h6
    |=> (rd_data_o & 32'h0000_001e) == 32'h0)
    else $error("control register reserved bits not zero");
  sel_echo_a: assert property (req_i.wr && ok && req_i.num == 3'h5 && !req_i.rd
    ##1 rd_ok && req_i.num == 3'h5 && !req_i.wr
    |=> rd_data_o == ($past(req_i.wdata, 2) & 32'h0000_0fff))
    else $error("select register read differs from write");

  cover property (rd_ok ##1 rd_valid_o);
  cover property (rq && !ok ##1 priv_fault_o);
  cover property (req_i.wr && ok && req_i.num == 3'h3);
endmodule

bind tct_test_regs tct_test_regs_sva chk_u (
  .core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i),
  .req_i(req_i),
  .cpl_i(cpl_i),
  .rd_data_o(rd_data_o),
  .rd_valid_o(rd_valid_o),
  .priv_fault_o(priv_fault_o)
);

// ===== tct_tlb_way.sv
/*
 * One way of the TLB: per line a tag, valid bit, attributes and the
 * physical page, with a lookup compare against paired attribute masks.
 * Assumes the caller supplies the line index and writes at most one line
 * per cycle.
 */
`timescale 1ns/1ps
`include "tct_params.svh"
module tct_tlb_way
  import tct_pkg::*;
#(
  parameter int LINES = `TCT_TLB_LINES,
  parameter int IW = $clog2(`TCT_TLB_LINES)
)
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [IW-1:0] idx_i,
  input wire logic [19:0] cmp_tag_i,
  input wire logic [5:0] cmp_pairs_i,
  input wire logic wr_en_i,
  input wire logic wr_valid_i,
  input wire tct_attr_s wr_attr_i,
  input wire logic [19:0] wr_data_i,
  output logic hit_o,
  output logic [19:0] data_o,
  output tct_attr_s attr_o
);
  logic [19:0] tag_ff [LINES];
  logic [19:0] data_ff [LINES];
  tct_attr_s attr_ff [LINES];
  logic [LINES-1:0] valid_ff;
  logic attr_ok;

  initial
  begin
    if (LINES != (1 << IW))
    begin
      $error("tct_tlb_way: LINES must equal 2**IW");
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      valid_ff <= '0;
    end
    else if (wr_en_i)
    begin
      valid_ff[idx_i] <= wr_valid_i; // R10
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (wr_en_i)
    begin
      tag_ff[idx_i] <= cmp_tag_i; // R9
      data_ff[idx_i] <= wr_data_i; // R1
      attr_ff[idx_i] <= wr_attr_i;
    end
  end

  // A pair of 10 asks for the bit set, 01 for it clear; 00 or 11 is ignored.
  always_comb
  begin
    attr_ok = 1'b1;
    if (cmp_pairs_i[5:4] == 2'h2 && !attr_ff[idx_i].dirty)
      attr_ok = 1'b0; // R11
    if (cmp_pairs_i[5:4] == 2'h1 && attr_ff[idx_i].dirty)
      attr_ok = 1'b0;
    if (cmp_pairs_i[3:2] == 2'h2 && !attr_ff[idx_i].user)
      attr_ok = 1'b0;
    if (cmp_pairs_i[3:2] == 2'h1 && attr_ff[idx_i].user)
      attr_ok = 1'b0;
    if (cmp_pairs_i[1:0] == 2'h2 && !attr_ff[idx_i].rw)
      attr_ok = 1'b0;
    if (cmp_pairs_i[1:0] == 2'h1 && attr_ff[idx_i].rw)
      attr_ok = 1'b0;
  end

  assign hit_o = valid_ff[idx_i] && (tag_ff[idx_i] == cmp_tag_i) && attr_ok;
  assign data_o = data_ff[idx_i];
  assign attr_o = attr_ff[idx_i];
endmodule
